// ### hdl/nmc_config_loader.sv
// Module: NVM management configuration loader with Wishbone register view
`timescale 1ns/100ps
`default_nettype none

module nmc_config_loader #(
    parameter int UNIT_CYCLES = nmc_pkg::NOTE_UNIT_CYC // Cycles per timeout unit
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // NVM word read port
    input wire logic sig_valid_i,
    output logic nvm_req_o,
    output logic [15:0] nvm_addr_o,
    input wire logic nvm_ack_i,
    input wire logic [15:0] nvm_data_i,
    // SMBus engine side
    input wire logic smb_cmd_valid_i,
    input wire logic [7:0] smb_cmd_i,
    input wire logic forced_reset_cmd_i,
    input wire logic note_start_i,
    input wire logic note_done_i,
    output logic cfg_ready_o,
    output nmc_pkg::nmc_cfg_t cfg_o,
    output logic block_read_hit_o,
    output logic int_reset_o,
    output logic note_timeout_o
);
    // ==========================================================
    // Elaboration checks
    generate
        if (UNIT_CYCLES < 1 || UNIT_CYCLES > 1048575) begin : g_bad_unit
            $error("UNIT_CYCLES out of range");
        end
    endgenerate

    localparam logic [19:0] UNIT_LAST = 20'(UNIT_CYCLES - 1); // Prescaler wrap

    // ==========================================================
    // Whole module state
    typedef struct packed {
        nmc_pkg::nmc_state_t st;   // Load sequencer
        logic [3:0] step;          // Word index in load sequence
        logic sig_ok;              // Signature state seen at load
        nmc_pkg::nmc_words_t w;    // Raw latched words
        nmc_pkg::nmc_cfg_t cfg;    // Decoded configuration
        logic ready;               // Configuration usable
        logic note_err;            // Image used reserved method
        logic arp_warn;            // Image cleared resolution-off bit
        logic req;                 // NVM request
        logic [15:0] naddr;        // NVM word address
        logic ack;                 // Bus ack
        logic err;                 // Bus error
        logic [31:0] rdat;         // Bus read data
        logic blk_hit;             // Block read command seen
        logic irst;                // Internal reset pulse
        logic tmr_run;             // Timeout running
        logic [19:0] pres;         // Unit prescaler
        logic [7:0] units;         // Units left
        logic tout;                // Timeout pulse
    } nmc_core_t;

    nmc_core_t s_r; // Registered state
    nmc_core_t s_nxt; // Next state

    // ==========================================================
    // Address of each load step
    function automatic logic [15:0] step_addr(input logic [3:0] step, input logic [15:0] vptr);
        logic [15:0] a;
        a = nmc_pkg::DEF_PTR;

        case (step)
            4'h0: a = nmc_pkg::W_PT_ADDR;
            4'h1: a = nmc_pkg::W_PT_RXEN;
            4'h2: a = nmc_pkg::W_PT_CTRL;
            4'h3: a = nmc_pkg::W_PT_FLAGS;
            4'h4: a = nmc_pkg::W_VSTA_PTR;
            4'h5: a = nmc_pkg::W_NSTOR_PTR;
            4'h6: a = nmc_pkg::W_VLAN_PTR;
            default: a = 16'(vptr + 16'(step - 4'h7));
        endcase
        return a;
    endfunction

    // ==========================================================
    // Decode raw words into configuration
    function automatic nmc_pkg::nmc_cfg_t decode(input nmc_pkg::nmc_words_t w);
        nmc_pkg::nmc_cfg_t c;
        c.own_addr = w.addr[15:9];
        c.ctl_addr = w.addr[7:1];
        c.rx_byte14 = w.rxen[15:8];
        c.rx_byte13 = w.rxen[7:0];
        // Low two bits forced clear so a misaligned image still stays within limit
        c.frag_max = 9'({w.ctrl[15:10], 2'b00}) + 9'h001;
        c.block_code = w.flags[nmc_pkg::FLG_BLK_SEL] ? nmc_pkg::BLK_CODE_1 : nmc_pkg::BLK_CODE_0;
        // Reserved method falls back to the alert line
        c.note_method = (w.flags[1:0] == nmc_pkg::NOTE_RSVD) ? 2'h0 : w.flags[1:0];
        c.arp_off = 1'b1;
        c.vlan_valid = (w.vlan_sig == nmc_pkg::VLAN_SIG) && (w.vlan_ver[7:0] == nmc_pkg::VLAN_VERSION);
        c.vlan_tag = c.vlan_valid ? {w.vlan_tag[15:13], 1'b0, w.vlan_tag[11:0]} : 16'h0000;
        return c;
    endfunction

    // ==========================================================
    // Next-state logic
    always_comb begin
        nmc_pkg::nmc_words_t wdef;
        logic hit;
        s_nxt = s_r;
        wdef = '0;
        wdef.addr = nmc_pkg::DEF_ADDR;
        wdef.rxen = nmc_pkg::DEF_RXEN;
        wdef.ctrl = nmc_pkg::DEF_CTRL;
        wdef.flags = nmc_pkg::DEF_FLAGS;
        hit = wb_cyc_i && wb_stb_i && !s_r.ack && !s_r.err;

        // Pulses drop after one cycle
        s_nxt.irst = 1'b0;
        s_nxt.blk_hit = 1'b0;
        s_nxt.tout = 1'b0;

        // Load sequencer; the checksum word is never read
        case (s_r.st)
            nmc_pkg::ST_IDLE: begin
                s_nxt.ready = 1'b0;
                s_nxt.step = 4'h0;
                s_nxt.sig_ok = sig_valid_i;
                if (sig_valid_i) begin
                    s_nxt.st = nmc_pkg::ST_REQ;
                end else begin
                    s_nxt.w = wdef;
                    s_nxt.st = nmc_pkg::ST_DONE;
                end
            end

            nmc_pkg::ST_REQ: begin
                // Address held with request
                s_nxt.req = 1'b1;
                s_nxt.naddr = step_addr(s_r.step, s_r.w.vlan_ptr);
                s_nxt.st = nmc_pkg::ST_WAIT;
            end

            nmc_pkg::ST_WAIT: begin
                if (nvm_ack_i) begin
                    s_nxt.req = 1'b0;
                    case (s_r.step)
                        4'h0: s_nxt.w.addr = nvm_data_i;
                        4'h1: s_nxt.w.rxen = nvm_data_i;
                        4'h2: s_nxt.w.ctrl = nvm_data_i;
                        4'h3: s_nxt.w.flags = nvm_data_i;
                        4'h4: s_nxt.w.vsta_ptr = nvm_data_i;
                        4'h5: s_nxt.w.nstor_ptr = nvm_data_i;
                        4'h6: s_nxt.w.vlan_ptr = nvm_data_i;
                        4'h7: s_nxt.w.vlan_sig = nvm_data_i;
                        4'h8: s_nxt.w.vlan_ver = nvm_data_i;
                        default: s_nxt.w.vlan_tag = nvm_data_i;
                    endcase
                    s_nxt.step = 4'(s_r.step + 4'h1);
                    // A zero pointer means no VLAN block to fetch
                    if (s_r.step == 4'(nmc_pkg::LOAD_STEPS - 1) ||
                        (s_r.step == 4'h6 && nvm_data_i == 16'h0000) ||
                        (s_r.step == 4'h7 && nvm_data_i != nmc_pkg::VLAN_SIG)) begin
                        s_nxt.st = nmc_pkg::ST_DONE;
                    end else begin
                        s_nxt.st = nmc_pkg::ST_REQ;
                    end
                end
            end

            nmc_pkg::ST_DONE: begin
                s_nxt.req = 1'b0;
                s_nxt.cfg = decode(s_r.w);
                s_nxt.note_err = (s_r.w.flags[1:0] == nmc_pkg::NOTE_RSVD);
                s_nxt.arp_warn = !s_r.w.flags[nmc_pkg::FLG_ARP_OFF];
                s_nxt.ready = 1'b1;
            end

            default: s_nxt.st = nmc_pkg::ST_IDLE;
        endcase

        // Block read command recognition
        if (s_r.ready && smb_cmd_valid_i && smb_cmd_i == s_r.cfg.block_code) begin
            s_nxt.blk_hit = 1'b1;
        end

        // Forced reset command, gated by its enable bit
        if (s_r.ready && forced_reset_cmd_i && s_r.w.flags[nmc_pkg::FLG_FORCE_RST]) begin
            s_nxt.irst = 1'b1;
        end

        // Notification timeout; a zero field disables it
        if (note_done_i || !s_r.ready) begin
            s_nxt.tmr_run = 1'b0;
        end else if (note_start_i && s_r.w.ctrl[7:0] != 8'h00) begin
            s_nxt.tmr_run = 1'b1;
            s_nxt.units = s_r.w.ctrl[7:0];
            s_nxt.pres = 20'h00000;
        end else if (s_r.tmr_run) begin
            if (s_r.pres == UNIT_LAST) begin
                s_nxt.pres = 20'h00000;
                s_nxt.units = 8'(s_r.units - 8'h01);
                // Last unit fires the flag
                if (s_r.units == 8'h01) begin
                    s_nxt.tmr_run = 1'b0;
                    s_nxt.tout = 1'b1;
                end
            end else begin
                s_nxt.pres = 20'(s_r.pres + 20'h00001);
            end
        end

        // Wishbone slave: one-cycle registered answer
        s_nxt.ack = 1'b0;
        s_nxt.err = 1'b0;

        // Unmapped offsets get an error
        if (hit) begin
            s_nxt.ack = 1'b1;
            s_nxt.rdat = 32'h00000000;
            case (wb_adr_i)
                // Flags from bit 0 up
                nmc_pkg::R_STATUS: s_nxt.rdat = {27'h0, s_r.arp_warn, s_r.note_err,
                                                 s_r.cfg.vlan_valid, s_r.sig_ok, s_r.ready};
                nmc_pkg::R_ADDR: s_nxt.rdat = {16'h0, s_r.w.addr};
                nmc_pkg::R_RXEN: s_nxt.rdat = {16'h0, s_r.w.rxen};
                nmc_pkg::R_CTRL: s_nxt.rdat = {16'h0, s_r.w.ctrl};
                nmc_pkg::R_FLAGS: s_nxt.rdat = {16'h0, s_r.w.flags};
                nmc_pkg::R_VSTA: s_nxt.rdat = {16'h0, s_r.w.vsta_ptr};
                nmc_pkg::R_NSTOR: s_nxt.rdat = {16'h0, s_r.w.nstor_ptr};
                nmc_pkg::R_VLPTR: s_nxt.rdat = {16'h0, s_r.w.vlan_ptr};
                nmc_pkg::R_VLTAG: s_nxt.rdat = {16'h0, s_r.cfg.vlan_tag};
                nmc_pkg::R_VLVER: s_nxt.rdat = {16'h0, s_r.w.vlan_ver};
                nmc_pkg::R_COMMAND: begin
                    // Reload only between loads, so a sequence never restarts halfway
                    if (wb_we_i && wb_sel_i[0] && wb_dat_i[0] && s_r.st == nmc_pkg::ST_DONE) begin
                        s_nxt.st = nmc_pkg::ST_IDLE;
                        s_nxt.ready = 1'b0;
                    end
                end
                default: begin
                    s_nxt.ack = 1'b0;
                    s_nxt.err = 1'b1;
                end
            endcase
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r <= '0;
            s_r.st <= nmc_pkg::ST_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // Outputs, all straight from state flops
    assign wb_dat_o = s_r.rdat;
    assign wb_ack_o = s_r.ack;
    assign wb_err_o = s_r.err;
    assign nvm_req_o = s_r.req;
    assign nvm_addr_o = s_r.naddr;
    assign cfg_ready_o = s_r.ready;
    assign cfg_o = s_r.cfg;
    assign block_read_hit_o = s_r.blk_hit;
    assign int_reset_o = s_r.irst;
    assign note_timeout_o = s_r.tout;
endmodule // nmc_config_loader

`default_nettype wire

// ### hdl/nmc_pkg.sv
// Package: constants, word offsets, field layouts and carriers for the NVM management config loader
package nmc_pkg;
    // ==========================================================
    // NVM word offsets
    localparam logic [15:0] W_PT_ADDR = 16'h0025;     // Pass-through SMBus addresses
    localparam logic [15:0] W_PT_RXEN = 16'h0026;     // Receive-enable bytes
    localparam logic [15:0] W_PT_CTRL = 16'h0027;     // Fragment size, notify timeout
    localparam logic [15:0] W_PT_FLAGS = 16'h0028;    // Init flags
    localparam logic [15:0] W_VSTA_PTR = 16'h0037;    // Virtual station-address pointer
    localparam logic [15:0] W_VLAN_PTR = 16'h003c;    // Netboot VLAN block pointer
    localparam logic [15:0] W_NSTOR_PTR = 16'h003d;   // Network-storage boot structure
    // ==========================================================
    // VLAN block layout and checks
    localparam logic [15:0] VLAN_SIG = 16'h4c56;      // ASCII V, L
    localparam logic [7:0] VLAN_VERSION = 8'h01;      // Structure version
    localparam int VLAN_WORDS = 3;                    // Signature, version/size, tag
    // ==========================================================
    // Init flag bit positions
    localparam int FLG_FORCE_RST = 4;                 // Forced reset enable
    localparam int FLG_ARP_OFF = 3;                   // Address resolution off
    localparam int FLG_BLK_SEL = 2;                   // Block read code select
    localparam logic [7:0] BLK_CODE_0 = 8'hc0;        // Block read code, select clear
    localparam logic [7:0] BLK_CODE_1 = 8'hd0;        // Block read code, select set
    localparam logic [1:0] NOTE_RSVD = 2'h3;          // Reserved notify method
    // ==========================================================
    // Hardware defaults when the signature is invalid
    localparam logic [15:0] DEF_ADDR = 16'h0000;
    localparam logic [15:0] DEF_RXEN = 16'h0000;
    localparam logic [15:0] DEF_CTRL = 16'h2000;      // Fragment size 0x20, timeout 0
    localparam logic [15:0] DEF_FLAGS = 16'h0008;     // Address resolution off
    localparam logic [15:0] DEF_PTR = 16'h0000;
    // ==========================================================
    // Bus register byte offsets
    localparam logic [5:0] R_STATUS = 6'h00;
    localparam logic [5:0] R_ADDR = 6'h04;
    localparam logic [5:0] R_RXEN = 6'h08;
    localparam logic [5:0] R_CTRL = 6'h0c;
    localparam logic [5:0] R_FLAGS = 6'h10;
    localparam logic [5:0] R_VSTA = 6'h14;
    localparam logic [5:0] R_NSTOR = 6'h18;
    localparam logic [5:0] R_VLPTR = 6'h1c;
    localparam logic [5:0] R_VLTAG = 6'h20;
    localparam logic [5:0] R_VLVER = 6'h24;
    localparam logic [5:0] R_COMMAND = 6'h28;         // Bit 0 write: reload
    // ==========================================================
    // Timing
    localparam int CLK_NS = 25;                       // 40 MHz core clock
    localparam int NOTE_UNIT_NS = 1100000;            // Least time per timeout unit
    localparam int NOTE_UNIT_CYC = (NOTE_UNIT_NS + CLK_NS - 1) / CLK_NS;
    localparam int LOAD_STEPS = 10;                   // Seven fixed words, three block words
    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_REQ = 2'b01,
        ST_WAIT = 2'b11,
        ST_DONE = 2'b10
    } nmc_state_t;

    typedef struct packed {
        logic [15:0] addr;      // Own and controller addresses
        logic [15:0] rxen;      // Receive-enable bytes
        logic [15:0] ctrl;      // Fragment size and timeout
        logic [15:0] flags;     // Init flags
        logic [15:0] vsta_ptr;  // Virtual station-address pointer
        logic [15:0] nstor_ptr; // Network-storage boot pointer
        logic [15:0] vlan_ptr;  // VLAN block pointer
        logic [15:0] vlan_sig;  // VLAN signature as read
        logic [15:0] vlan_ver;  // Size and version
        logic [15:0] vlan_tag;  // Port tag
    } nmc_words_t;

    typedef struct packed {
        logic [6:0] own_addr;
        logic [6:0] ctl_addr;
        logic [7:0] rx_byte14;
        logic [7:0] rx_byte13;
        logic [8:0] frag_max;
        logic [7:0] block_code;
        logic [1:0] note_method;
        logic arp_off;
        logic vlan_valid;
        logic [15:0] vlan_tag;
    } nmc_cfg_t;
endpackage : nmc_pkg

// ### verification/nmc_config_loader_properties.sv
// Checker: concurrent properties for the NVM management config loader
`timescale 1ns/100ps
`default_nettype none
module nmc_config_loader_chk #(
    parameter int UNIT_CYCLES = 4 // Timeout unit, handed on by the bind
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire logic nvm_req_o,
    input wire logic [15:0] nvm_addr_o,
    input wire logic nvm_ack_i,
    input wire logic smb_cmd_valid_i,
    input wire logic [7:0] smb_cmd_i,
    input wire logic forced_reset_cmd_i,
    input wire logic cfg_ready_o,
    input wire nmc_pkg::nmc_cfg_t cfg_o,
    input wire logic block_read_hit_o,
    input wire logic int_reset_o
);
    // ==========================================================
    // Properties, all on the core clock
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    property p_ack_next;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o != wb_err_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("bus answer missing or doubled");
    property p_err_unmap;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && wb_adr_i >= 6'h2c |=> wb_err_o;
    endproperty
    a_err_unmap: assert property (p_err_unmap) else $error("unmapped offset not refused");
    property p_no_sum_word;
        nvm_req_o |-> nvm_addr_o != 16'h003f;
    endproperty
    a_no_sum_word: assert property (p_no_sum_word) else $error("checksum word was fetched");
    property p_nvm_hold;
        nvm_req_o && !nvm_ack_i |=> nvm_req_o && $stable(nvm_addr_o);
    endproperty
    a_nvm_hold: assert property (p_nvm_hold) else $error("image request dropped early");
    property p_blk_hit;
        cfg_ready_o && smb_cmd_valid_i |=> block_read_hit_o == ($past(smb_cmd_i) == $past(cfg_o.block_code));
    endproperty
    a_blk_hit: assert property (p_blk_hit) else $error("block read match wrong");
    property p_arp;
        cfg_ready_o |-> cfg_o.arp_off;
    endproperty
    a_arp: assert property (p_arp) else $error("address resolution not off");
    property p_frag;
        cfg_ready_o |-> cfg_o.frag_max[1:0] == 2'b01;
    endproperty
    a_frag: assert property (p_frag) else $error("fragment limit not dword plus one");
    property p_force;
        int_reset_o |-> $past(forced_reset_cmd_i && cfg_ready_o);
    endproperty
    a_force: assert property (p_force) else $error("internal reset without command");
endmodule // nmc_config_loader_chk
bind nmc_config_loader nmc_config_loader_chk #(.UNIT_CYCLES(UNIT_CYCLES)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .nvm_req_o(nvm_req_o), .nvm_addr_o(nvm_addr_o), .nvm_ack_i(nvm_ack_i), .smb_cmd_valid_i(smb_cmd_valid_i),
    .smb_cmd_i(smb_cmd_i), .forced_reset_cmd_i(forced_reset_cmd_i), .cfg_ready_o(cfg_ready_o), .cfg_o(cfg_o),
    .block_read_hit_o(block_read_hit_o), .int_reset_o(int_reset_o));
`default_nettype wire

// ### verification/nmc_nvm_model.sv
// Partner: behavioural NVM image answering word reads
`timescale 1ns/100ps
`default_nettype none
module nmc_nvm_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req_i,
    input wire logic [15:0] addr_i,
    input wire logic [2:0] dly_i,
    output logic ack_o,
    output logic [15:0] data_o
);
    logic [15:0] mem [256] = '{default: 16'h0000}; // Image words, filled by the bench
    logic [2:0] cnt_r; // Wait cycles left
    logic busy_r; // Request taken
    logic done_r; // Answer given, waiting for release
    int req_cnt; // Reads since reset
    // ==========================================================
    // Answer after dly_i cycles; released data flips so stale words never match
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_r <= 1'b0;
            done_r <= 1'b0;
            cnt_r <= 3'h0;
            ack_o <= 1'b0;
            data_o <= 16'h0000;
            req_cnt <= 0;
        end else begin
            ack_o <= 1'b0;
            if (ack_o) begin
                data_o <= ~data_o; // Released lines show the inverse
            end
            if (!busy_r && req_i) begin
                busy_r <= 1'b1;
                cnt_r <= dly_i;
                req_cnt <= req_cnt + 1;
            end else if (busy_r && cnt_r != 3'h0) begin
                cnt_r <= cnt_r - 3'h1;
            end else if (busy_r && !done_r) begin
                ack_o <= 1'b1;
                data_o <= mem[addr_i[7:0]];
                done_r <= 1'b1;
            end else if (done_r && !req_i) begin
                busy_r <= 1'b0;
                done_r <= 1'b0;
            end
        end
    end
endmodule // nmc_nvm_model
`default_nettype wire

// ### verification/tb_nmc_config_loader.sv
// Testbench: image loading, register view and SMBus side of the config loader
`timescale 1ns/100ps
`default_nettype none
module tb_nmc_config_loader;
    localparam int UC = 4; // Short timeout unit keeps the run brief
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o;
    logic [5:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic sig_valid_i, nvm_req_o, nvm_ack_i, smb_cmd_valid_i, forced_reset_cmd_i, note_start_i, note_done_i;
    logic [15:0] nvm_addr_o, nvm_data_i;
    logic [7:0] smb_cmd_i;
    logic cfg_ready_o, block_read_hit_o, int_reset_o, note_timeout_o;
    nmc_pkg::nmc_cfg_t cfg_o;
    logic [2:0] dly; // Image answer delay
    int error_cnt, tests_run;
    logic [32:0] exp_q [$]; // Expected {err, data} of bus reads
    logic [15:0] w [7]; // Expected fixed words
    logic [15:0] wa [7] = '{nmc_pkg::W_PT_ADDR, nmc_pkg::W_PT_RXEN, nmc_pkg::W_PT_CTRL, nmc_pkg::W_PT_FLAGS,
        nmc_pkg::W_VSTA_PTR, nmc_pkg::W_NSTOR_PTR, nmc_pkg::W_VLAN_PTR};
    logic [5:0] ra [7] = '{nmc_pkg::R_ADDR, nmc_pkg::R_RXEN, nmc_pkg::R_CTRL, nmc_pkg::R_FLAGS,
        nmc_pkg::R_VSTA, nmc_pkg::R_NSTOR, nmc_pkg::R_VLPTR};
    nmc_config_loader #(.UNIT_CYCLES(UC)) u_nmc_config_loader (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .sig_valid_i(sig_valid_i),
        .nvm_req_o(nvm_req_o), .nvm_addr_o(nvm_addr_o), .nvm_ack_i(nvm_ack_i), .nvm_data_i(nvm_data_i),
        .smb_cmd_valid_i(smb_cmd_valid_i), .smb_cmd_i(smb_cmd_i), .forced_reset_cmd_i(forced_reset_cmd_i),
        .note_start_i(note_start_i), .note_done_i(note_done_i), .cfg_ready_o(cfg_ready_o), .cfg_o(cfg_o),
        .block_read_hit_o(block_read_hit_o), .int_reset_o(int_reset_o), .note_timeout_o(note_timeout_o));
    nmc_nvm_model u_nmc_nvm_model (.clk_i(clk_i), .rst_i(rst_i), .req_i(nvm_req_o), .addr_i(nvm_addr_o),
        .dly_i(dly), .ack_o(nvm_ack_i), .data_o(nvm_data_i));
    // ==========================================================
    // Clock, shared tasks
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    task automatic chk(input string n, input logic [66:0] e, input logic [66:0] s);
        tests_run++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic close_out();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Classic single cycle: hold until answer sampled, then release
    task automatic wb(input logic we, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, d, 4'hf};
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    task automatic rd(input logic [5:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask
    // Monitor: each read answer against the oldest note
    always @(posedge clk_i) begin : mon
        logic [32:0] e;
        if ((wb_ack_o === 1'b1 || wb_err_o === 1'b1) && wb_we_i === 1'b0) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 33'h1ffffffff;
            chk("wb_read", 67'(e), 67'({wb_err_o, wb_ack_o ? wb_dat_o : 32'h0}));
        end
    end
    function automatic nmc_pkg::nmc_cfg_t exp_cfg(input logic vok, input logic [15:0] tag);
        nmc_pkg::nmc_cfg_t e;
        e = {w[0][15:9], w[0][7:1], w[1], {1'b0, w[2][15:10], 2'b00} + 9'h001, 10'h0, 1'b1, vok, 16'h0};
        e.block_code = w[3][2] ? nmc_pkg::BLK_CODE_1 : nmc_pkg::BLK_CODE_0;
        e.note_method = (w[3][1:0] == nmc_pkg::NOTE_RSVD) ? 2'b00 : w[3][1:0];
        e.vlan_tag = vok ? tag : 16'h0000;
        return e;
    endfunction
    // ==========================================================
    // One boot: build image, reset, check fields, registers and SMBus side
    task automatic run(input int k, input logic sig);
        int n;
        logic [15:0] s;
        logic [7:0] cd [3];
        w = '{{7'($urandom), 1'b0, 7'($urandom), 1'b0}, 16'($urandom), {6'($urandom), 2'b00,
            8'($urandom_range(0, 3))}, {10'h0, 1'b1, k[1], 1'b1, k[0], k[1:0]}, 16'($urandom), 16'($urandom), 16'h0040};
        for (int i = 0; i < 7; i++) u_nmc_nvm_model.mem[wa[i][7:0]] = w[i];
        u_nmc_nvm_model.mem[8'h40] = (k == 3) ? 16'h4c57 : 16'h4c56;
        u_nmc_nvm_model.mem[8'h41] = 16'h0601;
        u_nmc_nvm_model.mem[8'h42] = 16'($urandom) & 16'hefff;
        s = 16'h0000;
        for (int i = 0; i < 63; i++) s += u_nmc_nvm_model.mem[i];
        u_nmc_nvm_model.mem[8'h3f] = 16'hbaba - s + 16'(k); // Balanced only for images built with k of 0
        if (!sig) w = '{nmc_pkg::DEF_ADDR, nmc_pkg::DEF_RXEN, nmc_pkg::DEF_CTRL, nmc_pkg::DEF_FLAGS,
            nmc_pkg::DEF_PTR, nmc_pkg::DEF_PTR, nmc_pkg::DEF_PTR};
        {rst_i, sig_valid_i, dly} <= {1'b1, sig, 3'($urandom_range(0, 4))};
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int j = 0; j < 2; j++) begin
            n = 0;
            do begin
                @(posedge clk_i);
                n++;
            end while (cfg_ready_o !== 1'b1 && n < 2000);
            chk("cfg", exp_cfg(sig && k != 3, u_nmc_nvm_model.mem[8'h42]), cfg_o);
            if (j == 0) wb(1'b1, nmc_pkg::R_COMMAND, 32'h1);
        end
        chk("image_reads", 67'(sig ? (k == 3 ? 16 : 20) : 0), 67'(u_nmc_nvm_model.req_cnt));
        wb(1'b1, nmc_pkg::R_ADDR, 32'($urandom)); // Read-only offset, write must vanish
        for (int i = 0; i < 7; i++) rd(ra[i], {17'h0, w[i]});
        rd(nmc_pkg::R_STATUS, {28'h0, sig && k == 3, sig && k != 3, sig, 1'b1});
        rd(6'h2c, {1'b1, 32'h0}); // Unmapped offset refused
        cd = '{nmc_pkg::BLK_CODE_0, nmc_pkg::BLK_CODE_1, 8'($urandom_range(0, 191))};
        for (int i = 0; i < 3; i++) begin
            {smb_cmd_valid_i, smb_cmd_i} <= {1'b1, cd[i]};
            @(posedge clk_i);
            {smb_cmd_valid_i, smb_cmd_i} <= {1'b0, 8'($urandom)};
            @(posedge clk_i);
            chk("block_hit", 67'(cd[i] == exp_cfg(1'b0, 16'h0).block_code), 67'(block_read_hit_o));
        end
        note_start_i <= 1'b1;
        @(posedge clk_i);
        note_start_i <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (note_timeout_o !== 1'b1 && n < 60);
        chk("timeout", 67'(w[2][7:0] == 8'h0 ? 60 : w[2][7:0] * UC + 1), 67'(n));
        note_start_i <= 1'b1;
        @(posedge clk_i);
        {note_start_i, note_done_i} <= 2'b01;
        @(posedge clk_i);
        note_done_i <= 1'b0;
        n = 0;
        repeat (20) @(posedge clk_i) n += int'(note_timeout_o === 1'b1);
        chk("timeout_stopped", 67'(0), 67'(n));
        forced_reset_cmd_i <= 1'b1;
        @(posedge clk_i);
        forced_reset_cmd_i <= 1'b0;
        @(posedge clk_i);
        chk("int_reset", 67'(w[3][4]), 67'(int_reset_o));
    endtask
    // ==========================================================
    // Main sequence: four flag mixes, then an invalid signature
    initial begin
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = {4'h8, 6'h0, 4'h0, 32'h0};
        {sig_valid_i, smb_cmd_valid_i, smb_cmd_i, forced_reset_cmd_i, note_start_i, note_done_i, dly} = 16'h0000;
        error_cnt = 0;
        tests_run = 0;
        void'($urandom(32'h0440));
        for (int k = 0; k < 4; k++) run(k, 1'b1);
        run(0, 1'b0);
        chk("queue_empty", 67'(0), 67'(exp_q.size()));
        close_out();
    end
    // Watchdog: whole run needs well under two thousand cycles
    initial begin
        #(25 * 40000);
        error_cnt++;
        close_out();
    end
endmodule // tb_nmc_config_loader
`default_nettype wire
